//--- dv/frcl_link_monitor.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Checker beside the programmer-to-sensor link
module frcl_link_monitor (
  input wire logic                        ref_clk_in,
  input wire logic                        srst_in,
  input wire logic                        cmd_valid,
  input wire frcl_pkg::frcl_cmd_t         cmd_kind,
  input wire logic [frcl_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [frcl_pkg::DATA_W-1:0] cmd_wdata,
  input wire logic                        rsp_valid,
  input wire logic [frcl_pkg::DATA_W-1:0] rsp_data
);
  import frcl_pkg::*;
  logic rd_cmd;
  logic wr_cmd;
  logic st_cmd;
  // Decoded kinds as plain nets, so $past sees a signal
  assign rd_cmd = cmd_valid && cmd_kind == FRCL_CMD_READ;
  assign wr_cmd = cmd_valid && cmd_kind == FRCL_CMD_WRITE;
  assign st_cmd = cmd_valid && cmd_kind == FRCL_CMD_STORE;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////////////////////////////////////////////
  // read answered next
  a_read_answered: assert property (rd_cmd |=> rsp_valid)
    else $error("read not answered one cycle later");
  a_answer_caused: assert property (rsp_valid |-> $past(rd_cmd))
    else $error("answer without a read");
  a_readout_width: assert property (rsp_valid |-> rsp_data[15:14] == 2'h0)
    else $error("readout wider than fourteen bits");
  a_reads_readout: assert property (rd_cmd |-> cmd_addr == REG_READOUT)
    else $error("programmer read another register");
  a_setup_analog: assert property ((wr_cmd && cmd_addr == REG_MODE) ##1 (wr_cmd && cmd_addr == REG_TEMP_LIN)
    |-> ($past(cmd_wdata) & FMT_MASK) == FMT_ANALOG_WORD) else $error("setup mode not analog");
  a_dsp_init_order: assert property (wr_cmd && cmd_addr == REG_TEMP_LIN |=> (wr_cmd && cmd_addr == REG_TEMP_SQR)
    ##1 (wr_cmd && cmd_addr == REG_TEMP_GRP) ##1 (wr_cmd && cmd_addr == REG_QOFF && cmd_wdata == QOFF_INIT)
    ##1 (wr_cmd && cmd_addr == REG_CLAMP_LO && cmd_wdata == CLAMP_LO_INIT)
    ##1 (wr_cmd && cmd_addr == REG_CLAMP_HI && cmd_wdata == CLAMP_HI_INIT) ##1 (wr_cmd && cmd_addr == REG_GAIN))
    else $error("setup writes out of order or wrong value");
  a_clamps_after_adjust: assert property (wr_cmd && cmd_addr == REG_CLAMP_LO |->
    $past(wr_cmd) && $past(cmd_addr) == REG_QOFF) else $error("clamp written before offset");
  a_store_after_final: assert property ((wr_cmd && cmd_addr == REG_CLAMP_HI) ##1 (wr_cmd && cmd_addr == REG_MODE)
    |=> st_cmd) else $error("final writes not stored");
  a_lock_stored: assert property (wr_cmd && cmd_addr == REG_LOCK |-> cmd_wdata == 16'h0001 ##1 st_cmd)
    else $error("lock write wrong or not stored");
  c_read: cover property (rd_cmd ##1 rsp_valid);
  c_lock: cover property (wr_cmd && cmd_addr == REG_LOCK);
  c_store: cover property (st_cmd);
endmodule // frcl_link_monitor
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
////////////////////////////////////////////////////////////////////////////////
// Programmer faces sensor A; sensor B is driven directly to reach lock and format cases
module testbench;
  import frcl_pkg::*;
  int          errors = 0;
  int          checks = 0;
  logic        ref_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        start, strobe, lock_req, pc_a, pc_b, done, busy, cal_err, a_lock, b_lock, got_v;
  logic [13:0] field_a, field_b, t1, t2, rd1, rd2;
  logic [15:0] mode_set, sens_set, pg_gain, pg_qoff, a_mode, a_gain, a_qoff, a_clo, a_chi, b_gain, g, q, got_d;
  frcl_link_if link_a ();
  frcl_link_if link_b ();
  // 25 MHz reference
  always #20 ref_clk_in = ~ref_clk_in;
  frcl_programmer i_frcl_programmer (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .link(link_a),
    .start_in(start), .point_strobe_in(strobe), .lock_in(lock_req), .mode_in(mode_set), .temp_lin_in(16'h000F),
    .temp_sqr_in(16'h0001), .temp_grp_in(16'h0001), .sens_init_in(sens_set), .target1_in(t1), .target2_in(t2),
    .clamp_low_in(16'h0040), .clamp_high_in(16'h0180), .busy_out(busy), .done_out(done), .cal_error_out(cal_err),
    .readout1_out(rd1), .readout2_out(rd2), .gain_out(pg_gain), .quiescent_offset_out(pg_qoff));
  frcl_sensor_regs i_frcl_sensor_regs (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .link(link_a),
    .power_cycle_in(pc_a), .field_value_in(field_a), .mode_out(a_mode), .gain_out(a_gain),
    .quiescent_offset_out(a_qoff), .clamp_low_out(a_clo), .clamp_high_out(a_chi), .locked_out(a_lock));
  frcl_sensor_regs i_frcl_sensor_regs_b (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .link(link_b),
    .power_cycle_in(pc_b), .field_value_in(field_b), .mode_out(), .gain_out(b_gain),
    .quiescent_offset_out(), .clamp_low_out(), .clamp_high_out(), .locked_out(b_lock));
  frcl_link_monitor i_frcl_link_monitor (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .cmd_valid(link_a.cmd_valid), .cmd_kind(link_a.cmd_kind), .cmd_addr(link_a.cmd_addr),
    .cmd_wdata(link_a.cmd_wdata), .rsp_valid(link_a.rsp_valid), .rsp_data(link_a.rsp_data));
  ////////////////////////////////////////////////////////////////////////////////
  // Inputs move 1 ns after the rising edge, clear of sampling
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One command on link B; the idle cycle after it keeps valid from toggling twice in a step
  task automatic send(frcl_cmd_t k, logic [3:0] a, logic [15:0] d);
    link_b.cmd_valid = 1'b1;
    link_b.cmd_kind = k;
    link_b.cmd_addr = a;
    link_b.cmd_wdata = d;
    tick(1);
    got_v = link_b.rsp_valid;
    got_d = link_b.rsp_data;
    link_b.cmd_valid = 1'b0;
    link_b.cmd_addr = ~a;
    link_b.cmd_wdata = ~d;
    tick(1);
  endtask
  task automatic rd_b(logic [3:0] a, logic [15:0] e, logic ans);
    send(FRCL_CMD_READ, a, 16'h0000);
    `CHK("answer", ans, got_v)
    if (ans) `CHK("read data", e, got_d)
  endtask
  task automatic pcycle_b();
    pc_b = 1'b1;
    tick(1);
    pc_b = 1'b0;
    tick(1);
  endtask
  // Strobe timing follows the setup script length; the done wait is bounded
  task automatic cal(logic [13:0] f1, logic [13:0] f2, logic lk);
    int i;
    lock_req = lk;
    field_a = f1;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    `CHK("busy", 1'b1, busy)
    tick(12);
    strobe = 1'b1;
    tick(1);
    strobe = 1'b0;
    tick(6);
    field_a = f2;
    tick(2);
    strobe = 1'b1;
    tick(1);
    strobe = 1'b0;
    for (i = 0; i < 100 && done !== 1'b1; i++) tick(1);
    if (done !== 1'b1) begin
      $display("[FAIL] done expected 1 seen %b", done);
      errors++;
      results();
    end
    tick(1);
  endtask
  task automatic check_good(int d1, int d2);
    g = 16'(int'(sens_set) * (int'(t2) - int'(t1)) / (d2 - d1));
    q = 16'((int'(t2) - (d2 - 8192) * (int'(t2) - int'(t1)) / (d2 - d1)) >>> 4);
    `CHK("readout1", 14'(d1), rd1)
    `CHK("readout2", 14'(d2), rd2)
    `CHK("gain", g, a_gain)
    `CHK("offset", q, a_qoff)
    `CHK("mode", mode_set, a_mode)
    `CHK("clamp low", 16'h0040, a_clo)
    `CHK("clamp high", 16'h0180, a_chi)
    `CHK("prog gain", g, pg_gain)
    `CHK("prog offset", q, pg_qoff)
    `CHK("no error", 1'b0, cal_err)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    start = 1'b0;
    strobe = 1'b0;
    lock_req = 1'b0;
    pc_a = 1'b0;
    pc_b = 1'b0;
    field_a = 14'h0000;
    field_b = 14'h0001;
    t1 = 14'h0800;
    t2 = 14'h3800;
    mode_set = 16'h00C8;
    sens_set = 16'h0100;
    link_b.cmd_valid = 1'b0;
    link_b.cmd_kind = FRCL_CMD_READ;
    link_b.cmd_addr = 4'h0;
    link_b.cmd_wdata = 16'h0000;
    repeat (6) @(posedge ref_clk_in);
    #1 srst_in = 1'b0;
    cal(14'h0400, 14'h3000, 1'b0);
    check_good(16'h0400, 16'h3000);
    $display("test calibration done");
    mode_set = 16'h0008;
    cal(14'h1000, 14'h2800, 1'b0);
    check_good(16'h1000, 16'h2800);
    $display("test recalibration done");
    cal(14'h1111, 14'h1111, 1'b0);
    `CHK("cal error", 1'b1, cal_err)
    `CHK("gain kept", sens_set, a_gain)
    $display("test equal readouts done");
    cal(14'h0400, 14'h3000, 1'b1);
    check_good(16'h0400, 16'h3000);
    `CHK("lock before power cycle", 1'b0, a_lock)
    pc_a = 1'b1;
    tick(1);
    pc_a = 1'b0;
    tick(1);
    `CHK("lock after power cycle", 1'b1, a_lock)
    `CHK("gain reloaded", g, a_gain)
    $display("test lock by programmer done");
    rd_b(REG_READOUT, 16'h2000, 1'b1);
    send(FRCL_CMD_WRITE, REG_MODE, 16'h00C0);
    rd_b(REG_READOUT, 16'h0000, 1'b1);
    send(FRCL_CMD_WRITE, REG_MODE, FMT_ANALOG_WORD);
    field_b = 14'h2C01;
    rd_b(REG_READOUT, 16'h200D, 1'b1);
    rd_b(4'hE, 16'h0000, 1'b1);
    send(FRCL_CMD_WRITE, REG_GAIN, 16'h1234);
    send(FRCL_CMD_WRITE, REG_LOCK, 16'h0001);
    send(FRCL_CMD_STORE, 4'h0, 16'h0000);
    rd_b(REG_GAIN, 16'h1234, 1'b1);
    send(FRCL_CMD_WRITE, REG_LOCK, 16'h0000);
    rd_b(REG_LOCK, 16'h0001, 1'b1);
    pcycle_b();
    `CHK("locked", 1'b1, b_lock)
    rd_b(REG_GAIN, 16'h0000, 1'b0);
    send(FRCL_CMD_WRITE, REG_GAIN, 16'h5555);
    `CHK("gain while locked", 16'h1234, b_gain)
    send(FRCL_CMD_WRITE, REG_LOCK, 16'h0000);
    send(FRCL_CMD_STORE, 4'h0, 16'h0000);
    pcycle_b();
    `CHK("lock stays", 1'b1, b_lock)
    $display("test direct link done");
    results();
  end
endmodule // testbench
`default_nettype wire

//--- inc/frcl_link_if.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Word-level programming link between programmer and sensor
interface frcl_link_if;
  logic                           cmd_valid;
  frcl_pkg::frcl_cmd_t            cmd_kind;
  logic [frcl_pkg::ADDR_W-1:0]    cmd_addr;
  logic [frcl_pkg::DATA_W-1:0]    cmd_wdata;
  logic                           rsp_valid;
  logic [frcl_pkg::DATA_W-1:0]    rsp_data;

  modport programmer (output cmd_valid, output cmd_kind, output cmd_addr, output cmd_wdata,
                      input rsp_valid, input rsp_data);
  modport sensor (input cmd_valid, input cmd_kind, input cmd_addr, input cmd_wdata,
                  output rsp_valid, output rsp_data);
endinterface // frcl_link_if
`default_nettype wire

//--- inc/frcl_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Shared constants for the field readout, calibration and lock register bank
package frcl_pkg;

  // Word and field widths of the programming link, and the width of the script step counter
  localparam int DATA_W    = 16;
  localparam int ADDR_W    = 4;
  localparam int READOUT_W = 14;
  localparam int STEP_W    = 3;

  // Link command kinds; code 3 is illegal and ignored
  typedef enum logic [1:0] {
    FRCL_CMD_READ  = 2'h0,
    FRCL_CMD_WRITE = 2'h1,
    FRCL_CMD_STORE = 2'h2
  } frcl_cmd_t;

  // Register indices on the link
  localparam logic [ADDR_W-1:0] REG_MODE     = 4'h0;
  localparam logic [ADDR_W-1:0] REG_GAIN     = 4'h1;
  localparam logic [ADDR_W-1:0] REG_QOFF     = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CLAMP_LO = 4'h3;
  localparam logic [ADDR_W-1:0] REG_CLAMP_HI = 4'h4;
  localparam logic [ADDR_W-1:0] REG_TEMP_LIN = 4'h5;
  localparam logic [ADDR_W-1:0] REG_TEMP_SQR = 4'h6;
  localparam logic [ADDR_W-1:0] REG_TEMP_GRP = 4'h7;
  localparam logic [ADDR_W-1:0] REG_GP0      = 4'h8;
  localparam logic [ADDR_W-1:0] REG_LOCK     = 4'hC;
  localparam logic [ADDR_W-1:0] REG_READOUT  = 4'hD;
  localparam int                STORE_COUNT  = 13;

  // Output format field of the mode register, bits 7 to 5
  localparam logic [DATA_W-1:0] FMT_MASK        = 16'h00E0;
  localparam logic [DATA_W-1:0] FMT_ANALOG_WORD = 16'h0000;

  // Lock bit position and reset values
  localparam int                LOCK_BIT     = 0;
  localparam logic [DATA_W-1:0] TEMP_GRP_RST = 16'h0001;
  localparam logic [DATA_W-1:0] REG_RST      = 16'h0000;

  // Initial calibration settings: 2.5 V offset, 0 V and 4.999 V clamps
  localparam logic [DATA_W-1:0] QOFF_INIT     = 16'h0200;
  localparam logic [DATA_W-1:0] CLAMP_LO_INIT = 16'h0000;
  localparam logic [DATA_W-1:0] CLAMP_HI_INIT = 16'h01FF;

  // Readout midpoint 8192 of full scale 16384, offset scaled by 1/16
  localparam logic signed [DATA_W-1:0] READOUT_MID = 16'sh2000;
  localparam int                       QOFF_SHIFT  = 4;

  // Last step of each host write script
  localparam logic [STEP_W-1:0] SETUP_LAST = 3'h7;
  localparam logic [STEP_W-1:0] FINAL_LAST = 3'h4;

endpackage
`default_nettype wire

//--- rtl/frcl_programmer.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Programmer end: runs a two-point calibration and optional lock
module frcl_programmer (
  input  wire logic                             ref_clk_in,
  input  wire logic                             srst_in,
  frcl_link_if.programmer                       link,
  input  wire logic                             start_in,
  input  wire logic                             point_strobe_in,
  input  wire logic                             lock_in,
  input  wire logic [frcl_pkg::DATA_W-1:0]      mode_in,
  input  wire logic [frcl_pkg::DATA_W-1:0]      temp_lin_in,
  input  wire logic [frcl_pkg::DATA_W-1:0]      temp_sqr_in,
  input  wire logic [frcl_pkg::DATA_W-1:0]      temp_grp_in,
  input  wire logic [frcl_pkg::DATA_W-1:0]      sens_init_in,
  input  wire logic [frcl_pkg::READOUT_W-1:0]   target1_in,
  input  wire logic [frcl_pkg::READOUT_W-1:0]   target2_in,
  input  wire logic [frcl_pkg::DATA_W-1:0]      clamp_low_in,
  input  wire logic [frcl_pkg::DATA_W-1:0]      clamp_high_in,
  output logic                                  busy_out,
  output logic                                  done_out,
  output logic                                  cal_error_out,
  output logic      [frcl_pkg::READOUT_W-1:0]   readout1_out,
  output logic      [frcl_pkg::READOUT_W-1:0]   readout2_out,
  output logic      [frcl_pkg::DATA_W-1:0]      gain_out,
  output logic      [frcl_pkg::DATA_W-1:0]      quiescent_offset_out
);
  import frcl_pkg::*;

  // Sequencer states, Gray coded along the calibration path
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_SETUP = 4'h1,
    ST_WAIT1 = 4'h3,
    ST_READ1 = 4'h2,
    ST_WAIT2 = 4'h6,
    ST_READ2 = 4'h7,
    ST_CALC  = 4'h5,
    ST_FINAL = 4'h4,
    ST_STORE = 4'hC,
    ST_LOCKW = 4'hD,
    ST_LOCKS = 4'hF,
    ST_DONE  = 4'hE
  } frcl_state_t;

  frcl_state_t          state_r;
  frcl_state_t          state_nxt;
  logic [STEP_W-1:0]    step_r;
  logic [STEP_W-1:0]    step_nxt;
  logic                 issued_r;
  logic                 issued_nxt;
  logic [READOUT_W-1:0] rd1_r;
  logic [READOUT_W-1:0] rd1_nxt;
  logic [READOUT_W-1:0] rd2_r;
  logic [READOUT_W-1:0] rd2_nxt;
  logic [DATA_W-1:0]    gain_r;
  logic [DATA_W-1:0]    gain_nxt;
  logic [DATA_W-1:0]    qoff_r;
  logic [DATA_W-1:0]    qoff_nxt;
  logic                 done_r;
  logic                 done_nxt;
  logic                 err_r;
  logic                 err_nxt;
  logic                 cmd_valid_r;
  logic                 cmd_valid_nxt;
  frcl_cmd_t            cmd_kind_r;
  frcl_cmd_t            cmd_kind_nxt;
  logic [ADDR_W-1:0]    cmd_addr_r;
  logic [ADDR_W-1:0]    cmd_addr_nxt;
  logic [DATA_W-1:0]    cmd_wdata_r;
  logic [DATA_W-1:0]    cmd_wdata_nxt;
  logic [READOUT_W-1:0] rsp_rev;
  logic [DATA_W-1:0]    mode_analog;

  ////////////////////////////////////////////////////////////////////////////////
  // undo reversed readout order
  for (genvar gi = 0; gi < READOUT_W; gi++) begin : g_rev
    assign rsp_rev[gi] = link.rsp_data[READOUT_W-1-gi];
  end

  assign mode_analog = (mode_in & ~FMT_MASK) | FMT_ANALOG_WORD;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-point arithmetic; the 16384/5 scale cancels as targets are readout codes
  logic signed [DATA_W-1:0] t1_s;
  logic signed [DATA_W-1:0] t2_s;
  logic signed [DATA_W-1:0] d1_s;
  logic signed [DATA_W-1:0] d2_s;
  logic signed [DATA_W-1:0] dt_s;
  logic signed [DATA_W-1:0] dd_s;
  logic signed [DATA_W-1:0] sens_s;
  logic signed [31:0]       gain_full;
  logic signed [31:0]       term_full;
  logic signed [31:0]       qoff_full;
  logic                     span_zero;

  assign t1_s      = $signed({2'b00, target1_in});
  assign t2_s      = $signed({2'b00, target2_in});
  assign d1_s      = $signed({2'b00, rd1_r});
  assign d2_s      = $signed({2'b00, rd2_r});
  assign sens_s    = $signed(sens_init_in);
  assign dt_s      = t2_s - t1_s;
  assign dd_s      = d2_s - d1_s;
  assign span_zero = (dd_s == '0); // Equal readouts give no slope

  assign gain_full = span_zero ? '0 : (32'(sens_s) * 32'(dt_s)) / 32'(dd_s);
  assign term_full = span_zero ? '0 : (32'(d2_s - READOUT_MID) * 32'(dt_s)) / 32'(dd_s);
  assign qoff_full = (32'(t2_s) - term_full) >>> QOFF_SHIFT;

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer; every command is registered before it reaches the link
  always_comb begin
    state_nxt     = state_r;
    step_nxt      = step_r;
    issued_nxt    = issued_r;
    rd1_nxt       = rd1_r;
    rd2_nxt       = rd2_r;
    gain_nxt      = gain_r;
    qoff_nxt      = qoff_r;
    done_nxt      = 1'b0;
    err_nxt       = err_r;
    cmd_valid_nxt = 1'b0;
    cmd_kind_nxt  = cmd_kind_r;
    cmd_addr_nxt  = cmd_addr_r;
    cmd_wdata_nxt = cmd_wdata_r;
    if (srst_in) begin
      state_nxt     = ST_IDLE;
      step_nxt      = '0;
      issued_nxt    = 1'b0;
      rd1_nxt       = '0;
      rd2_nxt       = '0;
      gain_nxt      = '0;
      qoff_nxt      = '0;
      err_nxt       = 1'b0;
      cmd_kind_nxt  = FRCL_CMD_READ;
      cmd_addr_nxt  = '0;
      cmd_wdata_nxt = '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_in) begin
            state_nxt = ST_SETUP;
            step_nxt  = '0;
            err_nxt   = 1'b0;
          end
        end
        ST_SETUP: begin
          cmd_valid_nxt = 1'b1;
          cmd_kind_nxt  = FRCL_CMD_WRITE;
          unique case (step_r)
            3'h0: begin cmd_addr_nxt = REG_MODE;     cmd_wdata_nxt = mode_analog;   end
            3'h1: begin cmd_addr_nxt = REG_TEMP_LIN; cmd_wdata_nxt = temp_lin_in;   end
            3'h2: begin cmd_addr_nxt = REG_TEMP_SQR; cmd_wdata_nxt = temp_sqr_in;   end
            3'h3: begin cmd_addr_nxt = REG_TEMP_GRP; cmd_wdata_nxt = temp_grp_in;   end
            3'h4: begin cmd_addr_nxt = REG_QOFF;     cmd_wdata_nxt = QOFF_INIT;     end
            3'h5: begin cmd_addr_nxt = REG_CLAMP_LO; cmd_wdata_nxt = CLAMP_LO_INIT; end
            3'h6: begin cmd_addr_nxt = REG_CLAMP_HI; cmd_wdata_nxt = CLAMP_HI_INIT; end
            3'h7: begin cmd_addr_nxt = REG_GAIN;     cmd_wdata_nxt = sens_init_in;  end
          endcase
          if (step_r == SETUP_LAST) begin
            state_nxt = ST_WAIT1;
            step_nxt  = '0;
          end else begin
            step_nxt = step_r + 3'h1;
          end
        end
        ST_WAIT1: begin
          if (point_strobe_in) begin
            state_nxt = ST_READ1;
          end
        end
        ST_READ1, ST_READ2: begin
          if (!issued_r) begin
            cmd_valid_nxt = 1'b1;
            cmd_kind_nxt  = FRCL_CMD_READ;
            cmd_addr_nxt  = REG_READOUT;
            issued_nxt    = 1'b1;
          end else if (link.rsp_valid) begin
            issued_nxt = 1'b0;
            if (state_r == ST_READ1) begin
              rd1_nxt   = rsp_rev;
              state_nxt = ST_WAIT2;
            end else begin
              rd2_nxt   = rsp_rev;
              state_nxt = ST_CALC;
            end
          end
        end
        ST_WAIT2: begin
          if (point_strobe_in) begin
            state_nxt = ST_READ2;
          end
        end
        ST_CALC: begin
          gain_nxt = gain_full[DATA_W-1:0];
          qoff_nxt = qoff_full[DATA_W-1:0];
          err_nxt  = span_zero;
          // A flat span would divide by zero, so nothing is written
          state_nxt = span_zero ? ST_DONE : ST_FINAL;
        end
        ST_FINAL: begin
          cmd_valid_nxt = 1'b1;
          cmd_kind_nxt  = FRCL_CMD_WRITE;
          cmd_addr_nxt  = REG_MODE;
          cmd_wdata_nxt = mode_in;
          unique case (step_r)
            3'h0: begin cmd_addr_nxt = REG_GAIN;     cmd_wdata_nxt = gain_r;        end
            3'h1: begin cmd_addr_nxt = REG_QOFF;     cmd_wdata_nxt = qoff_r;        end
            3'h2: begin cmd_addr_nxt = REG_CLAMP_LO; cmd_wdata_nxt = clamp_low_in;  end
            3'h3: begin cmd_addr_nxt = REG_CLAMP_HI; cmd_wdata_nxt = clamp_high_in; end
            default: begin cmd_addr_nxt = REG_MODE;  cmd_wdata_nxt = mode_in;       end
          endcase
          if (step_r == FINAL_LAST) begin
            state_nxt = ST_STORE;
            step_nxt  = '0;
          end else begin
            step_nxt = step_r + 3'h1;
          end
        end
        ST_STORE: begin
          cmd_valid_nxt = 1'b1;
          cmd_kind_nxt  = FRCL_CMD_STORE;
          state_nxt     = lock_in ? ST_LOCKW : ST_DONE;
        end
        ST_LOCKW: begin
          cmd_valid_nxt = 1'b1;
          cmd_kind_nxt  = FRCL_CMD_WRITE;
          cmd_addr_nxt  = REG_LOCK;
          cmd_wdata_nxt = DATA_W'(1) << LOCK_BIT;
          state_nxt     = ST_LOCKS;
        end
        ST_LOCKS: begin
          cmd_valid_nxt = 1'b1;
          cmd_kind_nxt  = FRCL_CMD_STORE;
          state_nxt     = ST_DONE;
        end
        ST_DONE: begin
          done_nxt  = 1'b1;
          state_nxt = ST_IDLE;
        end
        default: begin
          state_nxt = ST_IDLE; // Illegal code recovers to idle
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    state_r     <= state_nxt;
    step_r      <= step_nxt;
    issued_r    <= issued_nxt;
    rd1_r       <= rd1_nxt;
    rd2_r       <= rd2_nxt;
    gain_r      <= gain_nxt;
    qoff_r      <= qoff_nxt;
    done_r      <= done_nxt;
    err_r       <= err_nxt;
    cmd_valid_r <= cmd_valid_nxt;
    cmd_kind_r  <= cmd_kind_nxt;
    cmd_addr_r  <= cmd_addr_nxt;
    cmd_wdata_r <= cmd_wdata_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs; a locked sensor never answers, so a read then waits forever
  assign link.cmd_valid       = cmd_valid_r;
  assign link.cmd_kind        = cmd_kind_r;
  assign link.cmd_addr        = cmd_addr_r;
  assign link.cmd_wdata       = cmd_wdata_r;
  assign busy_out             = (state_r != ST_IDLE);
  assign done_out             = done_r;
  assign cal_error_out        = err_r;
  assign readout1_out         = rd1_r;
  assign readout2_out         = rd2_r;
  assign gain_out             = gain_r;
  assign quiescent_offset_out = qoff_r;

endmodule // frcl_programmer
`default_nettype wire

//--- rtl/frcl_sensor_regs.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Sensor end: calibration registers, nonvolatile copies, readout and lock
module frcl_sensor_regs (
  input  wire logic                             ref_clk_in,
  input  wire logic                             srst_in,
  frcl_link_if.sensor                           link,
  input  wire logic                             power_cycle_in,
  input  wire logic [frcl_pkg::READOUT_W-1:0]   field_value_in,
  output logic      [frcl_pkg::DATA_W-1:0]      mode_out,
  output logic      [frcl_pkg::DATA_W-1:0]      gain_out,
  output logic      [frcl_pkg::DATA_W-1:0]      quiescent_offset_out,
  output logic      [frcl_pkg::DATA_W-1:0]      clamp_low_out,
  output logic      [frcl_pkg::DATA_W-1:0]      clamp_high_out,
  output logic                                  locked_out
);
  import frcl_pkg::*;

  logic [DATA_W-1:0]    regs_r [STORE_COUNT];
  logic [DATA_W-1:0]    regs_nxt [STORE_COUNT];
  logic [DATA_W-1:0]    nv_r [STORE_COUNT];
  logic [DATA_W-1:0]    nv_nxt [STORE_COUNT];
  logic                 lock_active_r;
  logic                 lock_active_nxt;
  logic                 rsp_valid_r;
  logic                 rsp_valid_nxt;
  logic [DATA_W-1:0]    rsp_data_r;
  logic [DATA_W-1:0]    rsp_data_nxt;
  logic [READOUT_W-1:0] readout_rev;
  logic                 fmt_analog;
  logic [DATA_W-1:0]    readout_word;

  ////////////////////////////////////////////////////////////////////////////////
  // reversed bit order
  for (genvar gi = 0; gi < READOUT_W; gi++) begin : g_rev
    assign readout_rev[gi] = field_value_in[READOUT_W-1-gi];
  end

  assign fmt_analog = (regs_r[REG_MODE] & FMT_MASK) == FMT_ANALOG_WORD;
  assign readout_word = fmt_analog ? {{(DATA_W-READOUT_W){1'b0}}, readout_rev} : '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bank, nonvolatile store and lock state
  always_comb begin
    regs_nxt        = regs_r;
    nv_nxt          = nv_r;
    lock_active_nxt = lock_active_r;
    rsp_valid_nxt   = 1'b0;
    rsp_data_nxt    = rsp_data_r;
    if (srst_in) begin
      for (int i = 0; i < STORE_COUNT; i++) begin
        regs_nxt[i] = (i == int'(REG_TEMP_GRP)) ? TEMP_GRP_RST : REG_RST;
        nv_nxt[i]   = (i == int'(REG_TEMP_GRP)) ? TEMP_GRP_RST : REG_RST;
      end
      lock_active_nxt = 1'b0;
      rsp_data_nxt    = '0;
    end else if (power_cycle_in) begin
      regs_nxt        = nv_r;
      lock_active_nxt = nv_r[REG_LOCK][LOCK_BIT];
    end else if (link.cmd_valid && !lock_active_r) begin
      unique case (link.cmd_kind)
        FRCL_CMD_READ: begin
          rsp_valid_nxt = 1'b1;
          if (link.cmd_addr == REG_READOUT) begin
            rsp_data_nxt = readout_word;
          end else if (int'(link.cmd_addr) < STORE_COUNT) begin
            rsp_data_nxt = regs_r[link.cmd_addr];
          end else begin
            rsp_data_nxt = '0; // Unmapped index reads zero
          end
        end
        FRCL_CMD_WRITE: begin
          if (link.cmd_addr == REG_LOCK) begin
            regs_nxt[REG_LOCK][LOCK_BIT] = regs_r[REG_LOCK][LOCK_BIT] | link.cmd_wdata[LOCK_BIT];
          end else if (link.cmd_addr < REG_LOCK) begin
            regs_nxt[link.cmd_addr] = link.cmd_wdata;
          end
        end
        FRCL_CMD_STORE: begin
          nv_nxt = regs_r;
          nv_nxt[REG_LOCK][LOCK_BIT] = nv_r[REG_LOCK][LOCK_BIT] | regs_r[REG_LOCK][LOCK_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    regs_r        <= regs_nxt;
    nv_r          <= nv_nxt;
    lock_active_r <= lock_active_nxt;
    rsp_valid_r   <= rsp_valid_nxt;
    rsp_data_r    <= rsp_data_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs straight from registers
  assign link.rsp_valid        = rsp_valid_r;
  assign link.rsp_data         = rsp_data_r;
  assign mode_out              = regs_r[REG_MODE];
  assign gain_out              = regs_r[REG_GAIN];
  assign quiescent_offset_out  = regs_r[REG_QOFF];
  assign clamp_low_out         = regs_r[REG_CLAMP_LO];
  assign clamp_high_out        = regs_r[REG_CLAMP_HI];
  assign locked_out            = lock_active_r;

endmodule // frcl_sensor_regs
`default_nettype wire
